// ### inc/rsc_pkg.sv
// Constants and types shared by the reset source controller files.
// Assumes a 20 MHz system clock and an 8-bit special function register bus.
package rsc_pkg;

	// Register decode
	localparam logic [7:0] ADDR_SUPPLY_MON  = 8'hff;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'hef;
	localparam logic [7:0] PAGE_RESET       = 8'h00;

	// Supply monitor control fields
	localparam int MON_ENABLE_BIT = 7;
	localparam int MON_STATUS_BIT = 6;
	localparam int MON_LEVEL_BIT  = 5;

	// Reset cause fields
	localparam int CAUSE_PIN   = 0;
	localparam int CAUSE_POWER = 1;
	localparam int CAUSE_CLOCK = 2;
	localparam int CAUSE_WDOG  = 3;
	localparam int CAUSE_SOFT  = 4;
	localparam int CAUSE_CMP   = 5;
	localparam int CAUSE_FLASH = 6;
	localparam int CAUSE_W     = 7;

	// Reset values
	localparam logic [CAUSE_W-1:0] CAUSE_NONE  = 7'h00;
	localparam logic [CAUSE_W-1:0] CAUSE_PORV  = 7'h02;
	localparam logic [7:0]         BYTE_ZERO   = 8'h00;
	localparam logic               MON_LEVEL_RST = 1'b0;

	// Timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int RESET_HOLD_NS  = 500;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W         = 4;
	localparam int WDOG_DIV       = 12;
	localparam int WDOG_DIV_W     = 4;

	typedef enum logic {
		RSC_RUN,
		RSC_HOLD
	} rsc_state_t;

endpackage

// ### inc/rsc_wdog_if.sv
// Link between the reset controller and its watchdog unit.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface rsc_wdog_if;
	logic clear;
	logic service;
	logic disable_req;
	logic overflow;

	modport ctrl (
		output clear,
		output service,
		output disable_req,
		input  overflow
	);
	modport unit (
		input  clear,
		input  service,
		input  disable_req,
		output overflow
	);
endinterface

// ### verilog/rsc_watchdog.sv
// Watchdog unit clocked by a divide-by-twelve enable from the system clock.
// Assumes clear is held high for the whole of any system reset.
`timescale 1ns/100ps
module rsc_watchdog #(
	parameter int LIMIT_W = 8,
	parameter logic [LIMIT_W-1:0] LIMIT = 8'hff
) (
	input  wire logic   sys_clk_in,
	input  wire logic   rst_in,
	rsc_wdog_if.unit    link
);
	typedef struct packed {
		logic                              en;
		logic [rsc_pkg::WDOG_DIV_W-1:0]    div;
		logic [LIMIT_W-1:0]                cnt;
		logic                              ovf;
	} rsc_wdog_state_t;

	localparam logic [rsc_pkg::WDOG_DIV_W-1:0] DIV_LAST =
		rsc_pkg::WDOG_DIV_W'(rsc_pkg::WDOG_DIV - 1);

	rsc_wdog_state_t r;
	rsc_wdog_state_t next_r;

	always_comb begin
		next_r = r;
		next_r.ovf = 1'b0;
		if (link.clear) begin
			// Enabled and running from the divided clock after any reset
			next_r.en  = 1'b1;
			next_r.div = '0;
			next_r.cnt = '0;
		end else if (link.disable_req) begin
			next_r.en = 1'b0;
		end else if (link.service) begin
			next_r.cnt = '0;
		end else if (r.en) begin
			if (r.div == DIV_LAST) begin
				next_r.div = '0;
				if (r.cnt == LIMIT) begin
					next_r.ovf = 1'b1;
					next_r.cnt = '0;
				end else begin
					next_r.cnt = r.cnt + 1'b1;
				end
			end else begin
				next_r.div = r.div + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			r <= '{en: 1'b1, div: '0, cnt: '0, ovf: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign link.overflow = r.ovf;
endmodule

// ### verilog/rsc_controller.sv
// Reset source controller: supply monitor control, reset cause capture, reset hold.
// Assumes all pins synchronous to sys_clk_in and a single-cycle register bus.
//
// Overview of operation
// - Monitor enable bit gates monitor; it resets only when also selected.
// - Status bit 6 reads live monitor output, 1 when supply above threshold.
// - Level select bit 5 resets to 0; 0 low trip, 1 high trip.
// - Monitor control bits 4..0 read zero; writes to them ignored.
// - Monitor control register sits at address 0xFF, page 0x00.
// - Reset pin driven low forces reset; pin is active low.
// - Leaving a pin reset sets pin flag at cause bit 0.
// - Clock-loss detector timeout generates a system reset.
// - Clock-loss flag reads 1 only after a clock-loss reset.
// - Writing cause bit 2 enables or disables the clock-loss detector.
// - Non-power resets leave the reset pin undriven.
// - Writing 1 to bit 5 arms comparator reset on minus above plus.
// - Comparator flag reads 1 only after a comparator reset.
// - Watchdog enabled, clocked from system clock over twelve after reset.
// - Watchdog overflow resets device and sets watchdog flag.
// - Flash write, code read or fetch at reserved space resets device.
// - Forbidden flash access, or access without high selected monitor, resets.
// - Flash fault reset sets flag at cause bit 6.
// - Writing 1 to bit 4 resets at once; bit reads 1 afterwards.
// - Power-on or monitor reset sets the power flag.
// - Power-on forces monitor enable; other resets keep it.
// - Watchdog flag is read-only cause bit 3.
// - Reset cause register sits at address 0xEF, page 0x00.
`timescale 1ns/100ps
module rsc_controller #(
	parameter int              ADDR_W     = 16,
	parameter logic [ADDR_W-1:0] RESERVED_BASE = 16'hfc00,
	parameter int              WDOG_W     = 8,
	parameter logic [WDOG_W-1:0] WDOG_LIMIT = 8'hff
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	// Register bus
	input  wire logic [7:0]        sfr_addr_in,
	input  wire logic [7:0]        sfr_page_in,
	input  wire logic              sfr_wr_in,
	input  wire logic              sfr_rd_in,
	input  wire logic [7:0]        sfr_wdata_in,
	output logic      [7:0]        sfr_rdata_out,
	// Reset pin, two-way
	input  wire logic              rst_pin_n_in,
	output logic                   rst_pin_out,
	output logic                   rst_pin_oe_out,
	// Analog sources
	input  wire logic              supply_above_in,
	input  wire logic              clock_stall_in,
	input  wire logic              cmp_below_in,
	// Watchdog servicing from the counter array
	input  wire logic              wdog_service_in,
	input  wire logic              wdog_disable_in,
	// Flash accesses
	input  wire logic              flash_write_in,
	input  wire logic              store_write_enable_in,
	input  wire logic [ADDR_W-1:0] flash_addr_in,
	input  wire logic              code_read_in,
	input  wire logic              fetch_in,
	input  wire logic [ADDR_W-1:0] fetch_addr_in,
	input  wire logic              security_deny_in,
	// System side
	output logic                   sys_reset_out,
	output logic                   monitor_enable_out,
	output logic                   threshold_high_out
);
	typedef struct packed {
		rsc_pkg::rsc_state_t            state;
		logic [rsc_pkg::CAUSE_W-1:0]    cause;
		logic [rsc_pkg::CAUSE_W-1:0]    pend;
		logic [rsc_pkg::HOLD_W-1:0]     hold_cnt;
		logic                           mon_en;
		logic                           mon_high;
		logic                           mon_sel;
		logic                           cmp_arm;
		logic                           mcd_en;
		logic [7:0]                     rdata;
		logic                           sys_rst;
		logic                           pin_oe;
	} rsc_ctrl_state_t;

	localparam logic [rsc_pkg::HOLD_W-1:0] HOLD_LAST =
		rsc_pkg::HOLD_W'(rsc_pkg::RESET_HOLD_CYC - 1);

	localparam rsc_ctrl_state_t RESET_VALUE = '{
		state:    rsc_pkg::RSC_HOLD,
		cause:    rsc_pkg::CAUSE_NONE,
		pend:     rsc_pkg::CAUSE_PORV,
		hold_cnt: '0,
		mon_en:   1'b1,
		mon_high: rsc_pkg::MON_LEVEL_RST,
		mon_sel:  1'b1,
		cmp_arm:  1'b0,
		mcd_en:   1'b1,
		rdata:    rsc_pkg::BYTE_ZERO,
		sys_rst:  1'b1,
		pin_oe:   1'b1
	};

	rsc_ctrl_state_t r;
	rsc_ctrl_state_t next_r;

	rsc_wdog_if wdog ();

	rsc_watchdog #(
		.LIMIT_W (WDOG_W),
		.LIMIT   (WDOG_LIMIT)
	) u_watchdog (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.link       (wdog.unit)
	);

	// Highest priority source wins when several trip together
	function automatic logic [rsc_pkg::CAUSE_W-1:0] pick_cause(
		input logic [rsc_pkg::CAUSE_W-1:0] trips
	);
		logic [rsc_pkg::CAUSE_W-1:0] one;
		one = rsc_pkg::CAUSE_NONE;
		if (trips[rsc_pkg::CAUSE_POWER]) begin
			one[rsc_pkg::CAUSE_POWER] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_PIN]) begin
			one[rsc_pkg::CAUSE_PIN] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_CLOCK]) begin
			one[rsc_pkg::CAUSE_CLOCK] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_CMP]) begin
			one[rsc_pkg::CAUSE_CMP] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_WDOG]) begin
			one[rsc_pkg::CAUSE_WDOG] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_FLASH]) begin
			one[rsc_pkg::CAUSE_FLASH] = 1'b1;
		end else if (trips[rsc_pkg::CAUSE_SOFT]) begin
			one[rsc_pkg::CAUSE_SOFT] = 1'b1;
		end
		return one;
	endfunction

	function automatic logic in_reserved(input logic [ADDR_W-1:0] addr);
		return addr >= RESERVED_BASE;
	endfunction

	// Both registers share one page; only the address tells them apart
	function automatic logic reg_hit(
		input logic [7:0] page,
		input logic [7:0] addr,
		input logic [7:0] want
	);
		return page == rsc_pkg::PAGE_RESET && addr == want;
	endfunction

	logic                        wr_mon;
	logic                        wr_cause;
	logic                        rd_mon;
	logic                        rd_cause;
	logic                        monitor_trip;
	logic                        flash_access;
	logic                        flash_fault;
	logic                        hold_sources;
	logic                        pin_external;
	logic                        reserved_write;
	logic                        reserved_read;
	logic                        reserved_fetch;
	logic                        access_denied;
	logic                        access_unguarded;
	logic [rsc_pkg::CAUSE_W-1:0] trips;

	always_comb begin
		wr_mon   = 1'b0;
		wr_cause = 1'b0;
		rd_mon   = 1'b0;
		rd_cause = 1'b0;
		if (reg_hit(sfr_page_in, sfr_addr_in, rsc_pkg::ADDR_SUPPLY_MON)) begin
			wr_mon = sfr_wr_in;
			rd_mon = sfr_rd_in;
		end else if (reg_hit(sfr_page_in, sfr_addr_in, rsc_pkg::ADDR_RESET_CAUSE)) begin
			wr_cause = sfr_wr_in;
			rd_cause = sfr_rd_in;
		end
	end

	always_comb begin
		// Monitor trips only when switched on and selected as a source
		monitor_trip = r.mon_en && r.mon_sel && !supply_above_in;
		// Our own drive of the pin must not keep us in reset
		pin_external = !rst_pin_n_in && !r.pin_oe;
		flash_access = (flash_write_in && store_write_enable_in) || code_read_in;
		reserved_write = flash_write_in && store_write_enable_in &&
			in_reserved(flash_addr_in);
		reserved_read  = code_read_in && in_reserved(flash_addr_in);
		reserved_fetch = fetch_in && in_reserved(fetch_addr_in);
		access_denied  = flash_access && security_deny_in;
		// Flash is safe only while the monitor guards it at the high level
		access_unguarded = flash_access && !(r.mon_en && r.mon_high && r.mon_sel);
		flash_fault = reserved_write || reserved_read || reserved_fetch ||
			access_denied || access_unguarded;
		trips = rsc_pkg::CAUSE_NONE;
		trips[rsc_pkg::CAUSE_POWER] = monitor_trip;
		trips[rsc_pkg::CAUSE_PIN]   = pin_external;
		trips[rsc_pkg::CAUSE_CLOCK] = r.mcd_en && clock_stall_in;
		trips[rsc_pkg::CAUSE_CMP]   = r.cmp_arm && cmp_below_in;
		trips[rsc_pkg::CAUSE_WDOG]  = wdog.overflow;
		trips[rsc_pkg::CAUSE_FLASH] = flash_fault;
		trips[rsc_pkg::CAUSE_SOFT]  = wr_cause && sfr_wdata_in[rsc_pkg::CAUSE_SOFT];
		// Level sources keep the device held until they let go
		hold_sources = pin_external || monitor_trip;
	end

	always_comb begin
		next_r = r;
		case (r.state)
			rsc_pkg::RSC_RUN: begin
				if (wr_mon) begin
					next_r.mon_en   = sfr_wdata_in[rsc_pkg::MON_ENABLE_BIT];
					next_r.mon_high = sfr_wdata_in[rsc_pkg::MON_LEVEL_BIT];
				end
				if (wr_cause) begin
					next_r.mon_sel = sfr_wdata_in[rsc_pkg::CAUSE_POWER];
					next_r.mcd_en  = sfr_wdata_in[rsc_pkg::CAUSE_CLOCK];
					if (sfr_wdata_in[rsc_pkg::CAUSE_CMP]) begin
						next_r.cmp_arm = 1'b1;
					end
				end
				if (trips != rsc_pkg::CAUSE_NONE) begin
					next_r.state    = rsc_pkg::RSC_HOLD;
					next_r.pend     = pick_cause(trips);
					next_r.hold_cnt = '0;
					next_r.sys_rst  = 1'b1;
					// Only the supply monitor drives the pin low
					next_r.pin_oe   = trips[rsc_pkg::CAUSE_POWER];
				end
			end
			rsc_pkg::RSC_HOLD: begin
				if (r.hold_cnt != HOLD_LAST) begin
					next_r.hold_cnt = r.hold_cnt + 1'b1;
				end else if (!hold_sources) begin
					next_r.state   = rsc_pkg::RSC_RUN;
					next_r.sys_rst = 1'b0;
					next_r.pin_oe  = 1'b0;
					next_r.cause   = r.pend;
					next_r.cmp_arm = 1'b0;
					next_r.mcd_en  = 1'b1;
					if (r.pend[rsc_pkg::CAUSE_POWER]) begin
						next_r.mon_sel = 1'b1;
					end
				end
				if (!rst_pin_n_in && !r.pend[rsc_pkg::CAUSE_POWER]) begin
					// Pin asserted mid-hold takes over the recorded cause unless that cause is power
					next_r.pend = rsc_pkg::CAUSE_NONE;
					next_r.pend[rsc_pkg::CAUSE_PIN] = 1'b1;
				end
			end
			default: begin
				next_r = RESET_VALUE;
			end
		endcase
		if (rd_mon) begin
			next_r.rdata = rsc_pkg::BYTE_ZERO;
			next_r.rdata[rsc_pkg::MON_ENABLE_BIT] = r.mon_en;
			next_r.rdata[rsc_pkg::MON_STATUS_BIT] = supply_above_in;
			next_r.rdata[rsc_pkg::MON_LEVEL_BIT]  = r.mon_high;
		end else if (rd_cause) begin
			// Flags reflect the last cause, not the enables behind them
			next_r.rdata = {1'b0, r.cause};
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			// Power-on: monitor forced on at low level, pin driven
			r <= RESET_VALUE;
		end else begin
			r <= next_r;
		end
	end

	assign wdog.clear       = r.sys_rst;
	assign wdog.service     = wdog_service_in;
	assign wdog.disable_req = wdog_disable_in;

	assign sfr_rdata_out      = r.rdata;
	assign sys_reset_out      = r.sys_rst;
	assign rst_pin_oe_out     = r.pin_oe;
	assign monitor_enable_out = r.mon_en;
	assign threshold_high_out = r.mon_high;

	// Driven level is always low; the enable alone decides
	always_ff @(posedge sys_clk_in) begin
		rst_pin_out <= 1'b0;
	end
endmodule

// ### testbench/rsc_controller_assertions.sv
// Port checker for the reset source controller.
// Assumes binding to rsc_controller; all ports sampled on sys_clk_in.
`timescale 1ns/100ps
module rsc_controller_assertions #(
	parameter int                ADDR_W        = 16,
	parameter logic [ADDR_W-1:0] RESERVED_BASE = 16'hfc00
) (
	input wire logic              sys_clk_in,
	input wire logic              rst_in,
	input wire logic [7:0]        sfr_addr_in,
	input wire logic [7:0]        sfr_page_in,
	input wire logic              code_read_in,
	input wire logic              sfr_wr_in,
	input wire logic              sfr_rd_in,
	input wire logic [7:0]        sfr_wdata_in,
	input wire logic [7:0]        sfr_rdata_out,
	input wire logic              rst_pin_n_in,
	input wire logic              rst_pin_oe_out,
	input wire logic              supply_above_in,
	input wire logic              flash_write_in,
	input wire logic              store_write_enable_in,
	input wire logic [ADDR_W-1:0] flash_addr_in,
	input wire logic              fetch_in,
	input wire logic [ADDR_W-1:0] fetch_addr_in,
	input wire logic              security_deny_in,
	input wire logic              sys_reset_out,
	input wire logic              monitor_enable_out,
	input wire logic              threshold_high_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Other pages must not reach either register
	wire logic page0    = sfr_page_in == 8'h00;
	wire logic mon_rd   = sfr_rd_in && page0 && sfr_addr_in == 8'hff && !sys_reset_out;
	wire logic cause_rd = sfr_rd_in && page0 && sfr_addr_in == 8'hef && !sys_reset_out;
	wire logic soft_wr  = sfr_wr_in && page0 && sfr_addr_in == 8'hef && sfr_wdata_in[4];

	a_pin_enters_reset: assert property (!rst_pin_n_in && !sys_reset_out |=> sys_reset_out)
		else $error("pin low did not reset");
	a_soft_force_reset: assert property (soft_wr && !sys_reset_out |=> sys_reset_out)
		else $error("software force did not reset");
	a_status_live: assert property (mon_rd |=> sfr_rdata_out[6] == $past(supply_above_in))
		else $error("status bit not live");
	a_monitor_fields: assert property (mon_rd |=> sfr_rdata_out[7] == $past(monitor_enable_out)
		&& sfr_rdata_out[5] == $past(threshold_high_out)) else $error("monitor fields wrong");
	a_unused_zero: assert property (mon_rd |=> sfr_rdata_out[4:0] == 5'h00)
		else $error("unused bits not zero");
	a_cause_onehot: assert property (cause_rd |=> !sfr_rdata_out[7]
		&& $onehot(sfr_rdata_out[6:0])) else $error("cause not one-hot");
	a_pin_not_driven: assert property ($rose(sys_reset_out) && $past(supply_above_in)
		|-> !rst_pin_oe_out [*8]) else $error("pin driven on quiet reset");
	a_power_defaults: assert property ($fell(rst_in) |-> monitor_enable_out && !threshold_high_out)
		else $error("power-on defaults wrong");
	a_reserved_fault: assert property (!sys_reset_out && (flash_write_in && store_write_enable_in
		&& flash_addr_in >= RESERVED_BASE || fetch_in && fetch_addr_in >= RESERVED_BASE)
		|=> sys_reset_out) else $error("reserved access did not reset");
	a_denied_fault: assert property (!sys_reset_out && security_deny_in
		&& (flash_write_in && store_write_enable_in || code_read_in) |=> sys_reset_out)
		else $error("denied access did not reset");
	a_hold_length: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8] ##1 sys_reset_out [*2])
		else $error("reset hold too short");
endmodule

bind rsc_controller rsc_controller_assertions #(.ADDR_W(ADDR_W), .RESERVED_BASE(RESERVED_BASE)) u_chk (.*);

// ### testbench/rsc_pin_model.sv
// External reset circuitry on the active-low reset pin.
// Assumes a pulled-up open-drain pin that the device may also pull low.
`timescale 1ns/100ps
module rsc_pin_model (
	input  wire logic       sys_clk_in,
	input  wire logic       press_in,
	input  wire logic [7:0] hold_cyc_in,
	input  wire logic       dev_drive_in,
	input  wire logic       dev_oe_in,
	output logic            pin_n_out
);
	logic [7:0] left = 8'h00;
	always @(posedge sys_clk_in) begin
		if (press_in)
			left <= hold_cyc_in;
		else if (left != 8'h00)
			left <= left - 8'h01;
	end
	// Pull-up wins only while nobody pulls low
	assign pin_n_out = !((left != 8'h00) || (dev_oe_in && !dev_drive_in));
endmodule

// ### testbench/reset_source_controller_tb_top.sv
// Bench for the reset source controller: register tasks and reset scenarios.
// Assumes the checker is bound in and the pin model sits on the reset pin.
`timescale 1ns/100ps
module reset_source_controller_tb_top;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, press = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, page = 8'h00, rdata;
	logic        above = 1'b1, stall = 1'b0, below = 1'b0, svc = 1'b0, wdis = 1'b0;
	logic        fwr = 1'b0, swe = 1'b0, crd = 1'b0, fetch = 1'b0, deny = 1'b0;
	logic [15:0] faddr = 16'h0000;
	logic        pin_n, pin_drv, pin_oe, sres;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0, k;

	initial forever #25 clk = ~clk;
	// Short watchdog limit keeps overflow near 48 cycles
	rsc_controller #(.WDOG_LIMIT(8'h03)) uut (.sys_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr),
		.sfr_page_in(page), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
		.sfr_rdata_out(rdata), .rst_pin_n_in(pin_n), .rst_pin_out(pin_drv), .rst_pin_oe_out(pin_oe),
		.supply_above_in(above), .clock_stall_in(stall), .cmp_below_in(below),
		.wdog_service_in(svc), .wdog_disable_in(wdis), .flash_write_in(fwr),
		.store_write_enable_in(swe), .flash_addr_in(faddr), .code_read_in(crd), .fetch_in(fetch),
		.fetch_addr_in(faddr), .security_deny_in(deny), .sys_reset_out(sres),
		.monitor_enable_out(), .threshold_high_out());
	rsc_pin_model pin (.sys_clk_in(clk), .press_in(press), .hold_cyc_in(8'h0f),
		.dev_drive_in(pin_drv), .dev_oe_in(pin_oe), .pin_n_out(pin_n));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		check($sformatf("reg %h", a), rdata, exp);
	endtask
	// By reference, so the pulse reaches the design while the task runs
	task automatic pulse_quiet(ref logic s, input string what);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (3) @(negedge clk);
		check(what, {7'h00, sres}, 8'h00);
	endtask
	// Watchdog is stopped after an exit when stop_wdog is set so later steps are not cut short
	task automatic ride_reset(input logic stop_wdog);
		k = 0;
		while (sres !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		check("reset entered", {7'h00, sres}, 8'h01);
		while (sres !== 1'b0 && k < 200) begin
			@(negedge clk);
			k++;
		end
		wdis = stop_wdog;
		@(negedge clk);
		wdis = 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		ride_reset(1'b1);
		rd_reg(8'hff, 8'hc0);
		rd_reg(8'hef, 8'h02);
		rd_reg(8'hee, 8'h02);
		page = 8'h01;
		rd_reg(8'hff, 8'h02);
		page = 8'h00;
		wr_reg(8'hff, 8'hff);
		rd_reg(8'hff, 8'he0);
		wr_reg(8'hef, 8'h04);
		above = 1'b0;
		rd_reg(8'hff, 8'ha0);
		wr_reg(8'hff, 8'h00);
		wr_reg(8'hef, 8'h06);
		pulse_quiet(svc, "disabled monitor");
		above = 1'b1;
		wr_reg(8'hef, 8'h10);
		ride_reset(1'b1);
		rd_reg(8'hef, 8'h10);
		rd_reg(8'hff, 8'h40);
		press = 1'b1;
		@(negedge clk);
		press = 1'b0;
		ride_reset(1'b1);
		rd_reg(8'hef, 8'h01);
		below = 1'b1;
		pulse_quiet(svc, "comparator unarmed");
		wr_reg(8'hef, 8'h20);
		ride_reset(1'b1);
		below = 1'b0;
		rd_reg(8'hef, 8'h20);
		wr_reg(8'hef, 8'h00);
		pulse_quiet(stall, "clock check off");
		wr_reg(8'hef, 8'h04);
		stall = 1'b1;
		@(negedge clk);
		stall = 1'b0;
		ride_reset(1'b1);
		rd_reg(8'hef, 8'h04);
		wr_reg(8'hff, 8'ha0);
		// Let the monitor settle before it may reset
		repeat (4) @(negedge clk);
		wr_reg(8'hef, 8'h06);
		swe = 1'b1;
		faddr = 16'hfbff;
		pulse_quiet(fwr, "last user byte");
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				wr_reg(8'hef, 8'h04);
			@(negedge clk);
			fwr = (i == 0 || i == 3);
			fetch = (i == 1);
			crd = (i == 2);
			deny = (i == 2);
			faddr = (i < 2) ? 16'hfc00 : 16'h0010;
			@(negedge clk);
			fwr = 1'b0;
			fetch = 1'b0;
			crd = 1'b0;
			ride_reset(1'b1);
			deny = 1'b0;
			rd_reg(8'hef, 8'h40);
		end
		wr_reg(8'hef, 8'h10);
		ride_reset(1'b0);
		for (int i = 0; i < 80; i++) begin
			@(negedge clk);
			svc = (i % 20 == 0);
			check("serviced", {7'h00, sres}, 8'h00);
		end
		k = 0;
		while (sres !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		check("watchdog time", {7'h00, k >= 14 && k <= 34}, 8'h01);
		ride_reset(1'b1);
		rd_reg(8'hef, 8'h08);
		finish_test();
	end
endmodule
